// File: tma_defs.vh
// Constants shared by the timer array: modes, edges, counts and masks
`ifndef TMA_DEFS_VH
`define TMA_DEFS_VH

// Channel operating modes
`define TMA_MD_W          4
`define TMA_MD_INTERVAL   4'h0
`define TMA_MD_SQUARE     4'h1
`define TMA_MD_EVENT      4'h2
`define TMA_MD_DIVIDER    4'h3
`define TMA_MD_CAP_INTV   4'h4
`define TMA_MD_CAP_WIDTH  4'h5
`define TMA_MD_PWM_MASTER 4'h6
`define TMA_MD_OS_MASTER  4'h7
`define TMA_MD_SLAVE      4'h8

// Valid edge selection
`define TMA_EDGE_W        2
`define TMA_EDGE_FALL     2'h0
`define TMA_EDGE_RISE     2'h1
`define TMA_EDGE_BOTH     2'h2

// Counter values
`define TMA_CNT_INIT      16'hffff
`define TMA_CNT_ZERO      16'h0000
`define TMA_CNT_ONE       16'h0001

// Channel capability masks, bit n is channel n (unit 1 starts at bit 8)
`define TMA_DIV_OK_MASK   12'h01d
`define TMA_PIN_MASK      12'h0ff
`define TMA_LIN_CHANNEL   7

`endif

// File: tma_timer_array.v
// Two-unit sixteen-bit timer array with independent and combined modes
`timescale 1ns/1ps
`include "tma_defs.vh"

module tma_timer_array #(
  parameter CNT_W = 16,
  parameter U0_CH = 8,
  parameter U1_CH = 4
) (
  input  wire                            clk_sys,
  input  wire                            reset,
  input  wire [1:0]                      unit_enable,
  input  wire [U0_CH+U1_CH-1:0]          chan_start,
  input  wire [U0_CH+U1_CH-1:0]          chan_stop,
  input  wire [(U0_CH+U1_CH)*4-1:0]      chan_mode,
  input  wire [(U0_CH+U1_CH)*2-1:0]      chan_edge,
  input  wire [(U0_CH+U1_CH)*CNT_W-1:0]  chan_data,
  input  wire [U0_CH-1:0]                timer_capture_pin,
  input  wire                            lin_receive_line,
  input  wire                            lin_select,
  output wire [(U0_CH+U1_CH)*CNT_W-1:0]  channel_counter,
  output wire [(U0_CH+U1_CH)*CNT_W-1:0]  capture_value,
  output wire [U0_CH+U1_CH-1:0]          channel_done_irq,
  output wire [U0_CH-1:0]                timer_out_pin
);

  localparam NCH = U0_CH + U1_CH;

  ////////////////////////////////////////////////////////////////////////
  // Master tick distribution

  // Tick issued by each master, and tick seen by each slave
  wire [NCH-1:0] own_tick;
  wire [NCH-1:0] is_master;
  wire [NCH-1:0] follow_tick;

  genvar n;
  generate
    for (n = 0; n < NCH; n = n + 1) begin : g_link
      if (n == 0 || n == U0_CH) begin : g_first
        // A unit's first channel has no master below it
        assign follow_tick[n] = 1'b0;
      end else begin : g_rest
        // Chain through any non-master channels down to the nearest master
        assign follow_tick[n] = is_master[n-1] ? own_tick[n-1]
                                               : follow_tick[n-1];
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Channels

  generate
    for (n = 0; n < NCH; n = n + 1) begin : g_ch
      reg  [CNT_W-1:0] cnt_ff;
      reg  [CNT_W-1:0] cap_ff;
      reg              run_ff;
      reg              meas_ff;
      reg              out_ff;
      reg              irq_ff;
      reg              prev_ff;

      wire [3:0]       md;
      wire [1:0]       esel;
      wire [CNT_W-1:0] data;
      wire             unit_en;
      wire             in_lvl;
      wire             rise;
      wire             fall;
      reg              ev;
      wire             start_e;
      wire             end_e;
      reg              md_ok;
      wire             has_pin;
      wire             div_ok;
      wire             cnt_zero;

      // Mode flags, decoded once and shared by the mode check, master tick and start load below
      wire             md_intv;
      wire             md_sq;
      wire             md_div;
      wire             md_capi;
      wire             md_capw;
      wire             md_pwm;
      wire             md_os;
      wire             md_slv;

      assign md       = chan_mode[n*`TMA_MD_W +: `TMA_MD_W];
      assign esel     = chan_edge[n*`TMA_EDGE_W +: `TMA_EDGE_W];
      assign data     = chan_data[n*CNT_W +: CNT_W];
      assign unit_en  = (n < U0_CH) ? unit_enable[0] : unit_enable[1];
      assign has_pin  = (n < U0_CH) ? 1'b1 : 1'b0;
      assign div_ok   = (n < U0_CH) ? 1'b1 : 1'b0;
      assign cnt_zero = (cnt_ff == `TMA_CNT_ZERO);

      //////////////////////////////////////////////////////////////////
      // Mode decode

      assign md_intv  = (md == `TMA_MD_INTERVAL);
      assign md_sq    = (md == `TMA_MD_SQUARE);
      assign md_div   = (md == `TMA_MD_DIVIDER);
      assign md_capi  = (md == `TMA_MD_CAP_INTV);
      assign md_capw  = (md == `TMA_MD_CAP_WIDTH);
      assign md_pwm   = (md == `TMA_MD_PWM_MASTER);
      assign md_os    = (md == `TMA_MD_OS_MASTER);
      assign md_slv   = (md == `TMA_MD_SLAVE);

      //////////////////////////////////////////////////////////////////
      // Input select

      // Input source: pin, or the LIN line on the LIN channel
      if (n == `TMA_LIN_CHANNEL) begin : g_lin
        assign in_lvl = lin_select ? lin_receive_line
                                   : timer_capture_pin[n];
      end else if (n < U0_CH) begin : g_pin
        assign in_lvl = timer_capture_pin[n];
      end else begin : g_nopin
        // Unit 1 channels have no input pin
        assign in_lvl = 1'b0;
      end

      //////////////////////////////////////////////////////////////////
      // Edge detect

      // Inputs are synchronous, one delay gives the edges
      assign rise = in_lvl & ~prev_ff;
      assign fall = ~in_lvl & prev_ff;

      always @* begin
        ev = rise | fall;
        case (esel)
          `TMA_EDGE_RISE: begin
            ev = rise;
          end
          `TMA_EDGE_FALL: begin
            ev = fall;
          end
          default: begin
            ev = rise | fall;
          end
        endcase
      end

      // Width capture: falling start measures low width
      assign start_e = (esel == `TMA_EDGE_FALL) ? fall : rise;
      assign end_e   = (esel == `TMA_EDGE_FALL) ? rise : fall;

      //////////////////////////////////////////////////////////////////
      // Mode check and master tick

      // Refuse modes the channel cannot run; it then stays idle
      always @* begin
        md_ok = 1'b0;
        if (!has_pin) begin
          md_ok = md_intv;
        end else if (md_div) begin
          // Mask decides per channel, so a wrong pin count cannot leak
          md_ok = div_ok &&
                  (((`TMA_DIV_OK_MASK >> n) & 12'h001) != 12'h000);
        end else begin
          md_ok = (md <= `TMA_MD_SLAVE);
        end
      end

      assign is_master[n] = md_pwm || md_os;

      // Master end of period or end of delay
      assign own_tick[n] = unit_en && run_ff && md_ok && cnt_zero &&
                           (md_pwm || (md_os && meas_ff));

      //////////////////////////////////////////////////////////////////
      // Counter process

      always @(posedge clk_sys) begin
        if (reset || !unit_en) begin
          cnt_ff  <= `TMA_CNT_INIT;
          cap_ff  <= `TMA_CNT_ZERO;
          run_ff  <= 1'b0;
          meas_ff <= 1'b0;
          out_ff  <= 1'b0;
          irq_ff  <= 1'b0;
          // Seed from the line itself, so an idle high LIN gives no edge
          prev_ff <= in_lvl;
        end else begin
          prev_ff <= in_lvl;
          irq_ff  <= 1'b0;
          // Stop wins over start; the count holds for reading
          if (chan_stop[n]) begin
            run_ff  <= 1'b0;
            meas_ff <= 1'b0;
          end else if (chan_start[n]) begin
            run_ff  <= 1'b1;
            meas_ff <= 1'b0;
            out_ff  <= 1'b0;
            // Capture, one-shot master and slave modes start from zero
            if (md_capi || md_capw || md_os || md_slv) begin
              cnt_ff <= `TMA_CNT_ZERO;
            end else begin
              cnt_ff <= data;
            end
          end else if (run_ff && md_ok) begin
            case (md)
              `TMA_MD_INTERVAL,
              `TMA_MD_SQUARE,
              `TMA_MD_PWM_MASTER: begin
                if (cnt_zero) begin
                  cnt_ff <= data;
                  irq_ff <= 1'b1;
                  if (md_sq) begin
                    out_ff <= ~out_ff;
                  end
                end else begin
                  cnt_ff <= cnt_ff - `TMA_CNT_ONE;
                end
              end

              `TMA_MD_EVENT: begin
                if (ev) begin
                  // Interrupt on the programmed edge count
                  if (cnt_ff <= `TMA_CNT_ONE) begin
                    cnt_ff <= data;
                    irq_ff <= 1'b1;
                  end else begin
                    cnt_ff <= cnt_ff - `TMA_CNT_ONE;
                  end
                end
              end

              `TMA_MD_DIVIDER: begin
                if (ev) begin
                  if (cnt_zero) begin
                    cnt_ff <= data;
                    out_ff <= ~out_ff;
                    irq_ff <= 1'b1;
                  end else begin
                    cnt_ff <= cnt_ff - `TMA_CNT_ONE;
                  end
                end
              end

              `TMA_MD_CAP_INTV: begin
                if (ev) begin
                  meas_ff <= 1'b1;
                  cnt_ff  <= `TMA_CNT_ZERO;
                  if (meas_ff) begin
                    // Both edges give alternate low/high widths
                    cap_ff <= cnt_ff;
                    irq_ff <= 1'b1;
                  end
                end else if (meas_ff) begin
                  cnt_ff <= cnt_ff + `TMA_CNT_ONE;
                end
              end

              `TMA_MD_CAP_WIDTH: begin
                if (!meas_ff) begin
                  if (start_e) begin
                    meas_ff <= 1'b1;
                    cnt_ff  <= `TMA_CNT_ZERO;
                  end
                end else if (end_e) begin
                  // Repeats for wakeup then sync break
                  cap_ff  <= cnt_ff;
                  irq_ff  <= 1'b1;
                  meas_ff <= 1'b0;
                  cnt_ff  <= `TMA_CNT_ZERO;
                end else begin
                  cnt_ff <= cnt_ff + `TMA_CNT_ONE;
                end
              end

              `TMA_MD_OS_MASTER: begin
                if (!meas_ff) begin
                  // Trigger edge loads the delay
                  if (ev) begin
                    cnt_ff  <= data;
                    meas_ff <= 1'b1;
                  end
                end else if (cnt_zero) begin
                  irq_ff  <= 1'b1;
                  meas_ff <= 1'b0;
                end else begin
                  cnt_ff <= cnt_ff - `TMA_CNT_ONE;
                end
              end

              `TMA_MD_SLAVE: begin
                if (follow_tick[n]) begin
                  // Duty or width loads at the master tick
                  cnt_ff <= data;
                  // Zero duty keeps the pin low for the whole period
                  out_ff <= (data != `TMA_CNT_ZERO);
                end else if (!cnt_zero) begin
                  cnt_ff <= cnt_ff - `TMA_CNT_ONE;
                  if (cnt_ff == `TMA_CNT_ONE) begin
                    out_ff <= 1'b0;
                    irq_ff <= 1'b1;
                  end
                end
              end

              default: begin
                cnt_ff <= cnt_ff;
              end
            endcase
          end
        end
      end

      //////////////////////////////////////////////////////////////////
      // Port drive

      // Counter is observable only, no write path
      assign channel_counter[n*CNT_W +: CNT_W] = cnt_ff;
      assign capture_value[n*CNT_W +: CNT_W]   = cap_ff;
      assign channel_done_irq[n]               = irq_ff;
      if (n < U0_CH) begin : g_out
        assign timer_out_pin[n] = out_ff;
      end
    end
  endgenerate

endmodule

// File: tma_timer_array_asserts.sv
// Port checker for the timer array
`timescale 1ns/1ps
`include "tma_defs.vh"
module tma_timer_array_asserts #(
  parameter CNT_W = 16,
  parameter U0_CH = 8,
  parameter U1_CH = 4
) (
  input wire                           clk_sys,
  input wire                           reset,
  input wire [1:0]                     unit_enable,
  input wire [U0_CH+U1_CH-1:0]         chan_start,
  input wire [U0_CH+U1_CH-1:0]         chan_stop,
  input wire [(U0_CH+U1_CH)*4-1:0]     chan_mode,
  input wire [(U0_CH+U1_CH)*2-1:0]     chan_edge,
  input wire [(U0_CH+U1_CH)*CNT_W-1:0] chan_data,
  input wire [U0_CH-1:0]               timer_capture_pin,
  input wire                           lin_receive_line,
  input wire                           lin_select,
  input wire [(U0_CH+U1_CH)*CNT_W-1:0] channel_counter,
  input wire [(U0_CH+U1_CH)*CNT_W-1:0] capture_value,
  input wire [U0_CH+U1_CH-1:0]         channel_done_irq,
  input wire [U0_CH-1:0]               timer_out_pin
);
  localparam LO = U0_CH*CNT_W;
  localparam HI = (U0_CH+U1_CH)*CNT_W;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////////////////
  sequence s_stop0;
    chan_stop[0] && unit_enable[0];
  endsequence
  sequence s_go8;
    chan_start[8] && !chan_stop[8] && unit_enable[1] &&
    chan_mode[35:32] == `TMA_MD_INTERVAL && chan_data[143:128] == 16'h0003;
  endsequence
  property p_u0_off;
    !unit_enable[0] |=> channel_counter[LO-1:0] == {U0_CH{`TMA_CNT_INIT}};
  endproperty
  property p_u1_off;
    !unit_enable[1] |=> channel_counter[HI-1:LO] == {U1_CH{`TMA_CNT_INIT}};
  endproperty
  property p_u1_mode;
    channel_done_irq[8] |-> $past(chan_mode[35:32]) == `TMA_MD_INTERVAL;
  endproperty
  property p_div_ch1;
    chan_mode[7:4] == `TMA_MD_DIVIDER && $past(chan_mode[7:4]) ==
    `TMA_MD_DIVIDER |-> !channel_done_irq[1];
  endproperty
  property p_intv_reload;
    channel_done_irq[0] && chan_mode[3:0] == `TMA_MD_INTERVAL &&
    $stable(chan_data[15:0]) |-> channel_counter[15:0] == chan_data[15:0];
  endproperty
  property p_sq_toggle;
    channel_done_irq[0] && chan_mode[3:0] == `TMA_MD_SQUARE &&
    $stable(chan_mode[3:0]) |-> timer_out_pin[0] != $past(timer_out_pin[0]);
  endproperty
  // Held count only checked while no restart can reload it
  property p_stop_hold;
    s_stop0 ##1 (!chan_start[0] && unit_enable[0]) [*2]
    |-> $stable(channel_counter[15:0]);
  endproperty
  property p_intv_first;
    s_go8 |=> !channel_done_irq[8] [*4] ##1 channel_done_irq[8];
  endproperty
  property p_cap_clear;
    channel_done_irq[3] && chan_mode[15:12] == `TMA_MD_CAP_INTV
    |-> channel_counter[63:48] == `TMA_CNT_ZERO;
  endproperty
  property p_irq_pulse;
    channel_done_irq[8] && chan_data[143:128] != 16'h0000
    |=> !channel_done_irq[8];
  endproperty
  ////////////////////////////////////////////////////////////////////////
  a_u0_off: assert property (p_u0_off)
    else $error("unit 0 counters not all ones");
  a_u1_off: assert property (p_u1_off)
    else $error("unit 1 counters not all ones");
  a_u1_mode: assert property (p_u1_mode)
    else $error("unit 1 irq outside interval mode");
  a_div_ch1: assert property (p_div_ch1)
    else $error("channel 1 divides");
  a_intv_reload: assert property (p_intv_reload)
    else $error("interval reload wrong");
  a_sq_toggle: assert property (p_sq_toggle)
    else $error("square output not toggled");
  a_stop_hold: assert property (p_stop_hold)
    else $error("stopped counter moved");
  a_intv_first: assert property (p_intv_first)
    else $error("first interval irq mistimed");
  a_cap_clear: assert property (p_cap_clear)
    else $error("counter not cleared on capture");
  a_irq_pulse: assert property (p_irq_pulse)
    else $error("irq longer than one cycle");
endmodule

// File: tma_pulse_src.sv
// Pulse source model driving timer inputs and the LIN line
`timescale 1ns/1ps
module tma_pulse_src (
  input  wire       clk_sys,
  output reg  [7:0] timer_capture_pin,
  output reg        lin_receive_line
);
  initial begin
    timer_capture_pin = 8'h00;
    lin_receive_line = 1'b1; // Idle recessive high
  end
  // n pulses, hi clocks high then lo clocks low
  task automatic pulse(input int ch, input int hi, input int lo, input int n);
    repeat (n) begin
      @(negedge clk_sys);
      timer_capture_pin[ch] = 1'b1;
      repeat (hi) @(negedge clk_sys);
      timer_capture_pin[ch] = 1'b0;
      repeat (lo - 1) @(negedge clk_sys);
    end
  endtask
  // Low then high field on the receive line
  task automatic lin_bits(input int lo, input int hi);
    @(negedge clk_sys);
    lin_receive_line = 1'b0;
    repeat (lo) @(negedge clk_sys);
    lin_receive_line = 1'b1;
    repeat (hi) @(negedge clk_sys);
  endtask
endmodule

// File: tma_timer_array_bench.sv
// Self-checking bench for the timer array
`timescale 1ns/1ps
`include "tma_defs.vh"
module tma_timer_array_bench;
  reg  [0:0]   clk_sys = 1'b0;
  reg  [0:0]   reset = 1'b1;
  reg  [1:0]   unit_enable = 2'h3;
  reg  [11:0]  chan_start = 12'h000;
  reg  [11:0]  chan_stop = 12'h000;
  reg  [47:0]  chan_mode = 48'h0;
  reg  [23:0]  chan_edge = 24'h0;
  reg  [191:0] chan_data = 192'h0;
  reg  [0:0]   lin_select = 1'b0;
  wire [7:0]   cap_pin;
  wire         lin_line;
  wire [191:0] channel_counter;
  wire [191:0] capture_value;
  wire [11:0]  channel_done_irq;
  wire [7:0]   timer_out_pin;
  int          err_total = 0;
  int          tests_run = 0;
  int          cyc = 0;
  int          irq_n [12];
  int          n;
  int          b;
  always #12.5 clk_sys = ~clk_sys;
  tma_timer_array uut (.clk_sys(clk_sys), .reset(reset),
    .unit_enable(unit_enable), .chan_start(chan_start),
    .chan_stop(chan_stop), .chan_mode(chan_mode), .chan_edge(chan_edge),
    .chan_data(chan_data), .timer_capture_pin(cap_pin),
    .lin_receive_line(lin_line), .lin_select(lin_select),
    .channel_counter(channel_counter), .capture_value(capture_value),
    .channel_done_irq(channel_done_irq), .timer_out_pin(timer_out_pin));
  tma_pulse_src src (.clk_sys(clk_sys), .timer_capture_pin(cap_pin),
    .lin_receive_line(lin_line));
  // Irq tally and hang guard
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    for (int i = 0; i < 12; i++)
      irq_n[i] <= irq_n[i] + channel_done_irq[i];
    if (cyc == 20000) begin
      err_total++;
      finish_test;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task chk(input string what, input logic [15:0] seen, input logic [15:0] e);
    tests_run++;
    if (seen !== e) begin
      err_total++;
      $display("mismatch %s exp %h seen %h", what, e, seen);
    end
  endtask
  task cfg(input int ch, input logic [3:0] md, input logic [1:0] ed,
           input logic [15:0] d);
    @(negedge clk_sys);
    chan_mode[ch*4+:4] = md;
    chan_edge[ch*2+:2] = ed;
    chan_data[ch*16+:16] = d;
  endtask
  task kick(input logic [11:0] go, input logic [11:0] halt);
    @(negedge clk_sys);
    chan_start = go;
    chan_stop = halt;
    @(negedge clk_sys);
    chan_start = 12'h000;
    chan_stop = 12'h000;
  endtask
  task wait_irq(input int ch, output int k);
    k = 0;
    do begin
      @(posedge clk_sys);
      #1 k++;
    end while (channel_done_irq[ch] !== 1'b1 && k < 300);
  endtask
  task run_len(input int p, input logic v, output int k);
    k = 0;
    while (timer_out_pin[p] === v && k < 300) begin
      @(posedge clk_sys);
      #1 k++;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(negedge clk_sys);
    reset = 1'b0;
    for (int i = 0; i < 12; i++)
      chk("rst_cnt", channel_counter[i*16+:16], `TMA_CNT_INIT);
    cfg(0, `TMA_MD_INTERVAL, 2'h0, 16'h0002);
    cfg(8, `TMA_MD_INTERVAL, 2'h0, 16'h0003);
    kick(12'h101, 12'h000);
    wait_irq(0, n);
    chk("intv_first0", n, 3);
    wait_irq(8, n);
    chk("intv_first8", n, 1);
    chk("intv_pulse", channel_done_irq[0], 0);
    wait_irq(0, n);
    chk("intv_period", n, 2);
    kick(12'h000, 12'hfff);
    cfg(0, `TMA_MD_SQUARE, 2'h0, 16'h0004);
    kick(12'h001, 12'h000);
    run_len(0, 1'b0, n);
    run_len(0, 1'b1, n);
    chk("sq_high", n, 5);
    run_len(0, 1'b0, n);
    chk("sq_low", n, 5);
    cfg(2, `TMA_MD_EVENT, `TMA_EDGE_RISE, 16'h0003);
    kick(12'h000, 12'h001);
    kick(12'h004, 12'h000);
    b = irq_n[2];
    src.pulse(2, 1, 3, 2);
    chk("evt_early", irq_n[2] - b, 0);
    src.pulse(2, 1, 3, 1);
    repeat (4) @(negedge clk_sys);
    chk("evt_done", irq_n[2] - b, 1);
    cfg(0, `TMA_MD_DIVIDER, `TMA_EDGE_RISE, 16'h0001);
    cfg(1, `TMA_MD_DIVIDER, `TMA_EDGE_RISE, 16'h0001);
    kick(12'h003, 12'h000);
    b = irq_n[0];
    n = irq_n[1];
    src.pulse(0, 1, 1, 4);
    src.pulse(1, 1, 1, 4);
    repeat (4) @(negedge clk_sys);
    chk("div_ch0", irq_n[0] - b, 2);
    chk("div_ch1", irq_n[1] - n, 0);
    cfg(3, `TMA_MD_CAP_INTV, `TMA_EDGE_RISE, 16'h0000);
    kick(12'h008, 12'h000);
    b = irq_n[3];
    src.pulse(3, 2, 8, 3);
    repeat (4) @(negedge clk_sys);
    chk("cap_irq", irq_n[3] - b, 2);
    chk("cap_val", capture_value[63:48], 16'h0009);
    lin_select = 1'b1;
    cfg(7, `TMA_MD_CAP_WIDTH, `TMA_EDGE_FALL, 16'h0000);
    kick(12'h080, 12'h000);
    b = irq_n[7];
    src.lin_bits(20, 4);
    src.lin_bits(20, 4);
    chk("lin_low", capture_value[127:112], 16'h0013);
    chk("lin_irq", irq_n[7] - b, 2);
    cfg(7, `TMA_MD_CAP_INTV, `TMA_EDGE_BOTH, 16'h0000);
    kick(12'h080, 12'h000);
    b = irq_n[7];
    src.lin_bits(8, 8);
    src.lin_bits(8, 8);
    chk("sync_val", capture_value[127:112], 16'h0007);
    chk("sync_irq", irq_n[7] - b, 3);
    cfg(4, `TMA_MD_PWM_MASTER, 2'h0, 16'h0009);
    cfg(5, `TMA_MD_SLAVE, 2'h0, 16'h0003);
    kick(12'h030, 12'h000);
    run_len(5, 1'b0, n);
    run_len(5, 1'b1, n);
    chk("pwm_duty", n, 3);
    run_len(5, 1'b0, n);
    chk("pwm_rest", n, 7);
    cfg(0, `TMA_MD_OS_MASTER, `TMA_EDGE_RISE, 16'h0004);
    cfg(1, `TMA_MD_SLAVE, 2'h0, 16'h0002);
    kick(12'h003, 12'h000);
    b = irq_n[0];
    src.pulse(0, 1, 3, 1);
    run_len(1, 1'b0, n);
    run_len(1, 1'b1, n);
    chk("os_width", n, 2);
    chk("os_irq", irq_n[0] - b, 1);
    @(negedge clk_sys);
    unit_enable = 2'h0;
    @(negedge clk_sys);
    chk("off_cnt4", channel_counter[79:64], `TMA_CNT_INIT);
    unit_enable = 2'h3;
    finish_test;
  end
  task finish_test;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
endmodule
bind tma_timer_array tma_timer_array_asserts #(.CNT_W(CNT_W),
  .U0_CH(U0_CH), .U1_CH(U1_CH)) chk_i (.clk_sys(clk_sys), .reset(reset),
  .unit_enable(unit_enable), .chan_start(chan_start),
  .chan_stop(chan_stop), .chan_mode(chan_mode), .chan_edge(chan_edge),
  .chan_data(chan_data), .timer_capture_pin(timer_capture_pin),
  .lin_receive_line(lin_receive_line), .lin_select(lin_select),
  .channel_counter(channel_counter), .capture_value(capture_value),
  .channel_done_irq(channel_done_irq), .timer_out_pin(timer_out_pin));
